//--- design/bsc_pkg.sv
// Package for the skip, clear and call executor: encodings, widths and reset values.
// Assumes a single instruction clock shared by every user of the package.
package bsc_pkg;
    localparam int BSC_IW = 14;
    localparam int BSC_PCW = 13;
    localparam int BSC_FAW = 7;
    localparam logic [3:0] BSC_OP_SKIP = 4'h7;
    localparam int BSC_OP_SKIP_HI = 13;
    localparam int BSC_OP_SKIP_LO = 10;
    localparam logic [6:0] BSC_OP_CLR = 7'h03;
    localparam int BSC_OP_CLR_LO = 7;
    localparam logic [2:0] BSC_OP_CALL = 3'h4;
    localparam int BSC_OP_CALL_LO = 11;
    localparam int BSC_BIT_HI = 9;
    localparam int BSC_BIT_LO = 7;
    localparam int BSC_LIT_HI = 10;
    localparam int BSC_LATCH_HI = 4;
    localparam int BSC_LATCH_LO = 3;
    localparam logic [12:0] BSC_PC_RST = 13'h0000;
    localparam logic [7:0] BSC_CLR_VAL = 8'h00;
    localparam logic [12:0] BSC_PC_ONE = 13'h0001;
    localparam logic [6:0] BSC_ADDR_RST = 7'h00;
    localparam int BSC_CALL_CYCLES = 2;
    typedef enum logic [1:0] {
        BSC_ST_EXEC = 2'b00,
        BSC_ST_FLUSH = 2'b01
    } bsc_state_t;
endpackage : bsc_pkg

//--- design/bsc_decode.sv
// Opcode decoder for the three instructions of the executor.
// Assumes a full 14-bit instruction word on its input.
module bsc_decode
    import bsc_pkg::*;
(
    input wire logic [13:0] instr,
    output logic is_skip,
    output logic is_clr,
    output logic is_call
);
    always_comb begin
        is_skip = instr[BSC_OP_SKIP_HI:BSC_OP_SKIP_LO] == BSC_OP_SKIP;
        is_clr = instr[BSC_OP_SKIP_HI:BSC_OP_CLR_LO] == BSC_OP_CLR;
        is_call = instr[BSC_OP_SKIP_HI:BSC_OP_CALL_LO] == BSC_OP_CALL;
    end
endmodule : bsc_decode

//--- design/bsc_exec.sv
// Summary of operation
// - Decode skip opcode, bit index, register address.
// - Set bit: flush next word, two cycles.
// - Clear writes zero to register, sets zero.
// - Call pushes program counter plus one.
// - Call loads eleven literal bits into PC.
// - Call takes PC 12:11 from latch 4:3.
// - Call always takes two enabled cycles.
// Executes the skip, clear and call instructions of a small core.
// Assumes data reads return combinationally and instr_valid words come from same-clock fetch.
module bsc_exec
    import bsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [12:0] pc_cur,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] program_counter_high_latch,
    output logic [6:0] reg_addr_q,
    output logic [7:0] wr_data_q,
    output logic wr_en_q,
    output logic zero_set_q,
    output logic push_q,
    output logic [12:0] stack_top_entry_q,
    output logic pc_load_q,
    output logic [12:0] pc_next_q,
    output logic flush_q,
    output logic busy_q
);
    import bsc_pkg::*;
    logic is_skip;
    logic is_clr;
    logic is_call;
    bsc_state_t state_q, state_d;
    logic [6:0] reg_addr_d;
    logic [7:0] wr_data_d;
    logic wr_en_d, zero_set_d, push_d, pc_load_d, flush_d, busy_d;
    logic [12:0] stack_top_entry_d, pc_next_d;
    logic exec_ok;

    bsc_decode u_dec (
        .instr(instr),
        .is_skip(is_skip),
        .is_clr(is_clr),
        .is_call(is_call)
    );

    assign exec_ok = instr_valid && state_q == BSC_ST_EXEC;

    always_comb begin
        state_d = state_q;
        reg_addr_d = instr[BSC_FAW-1:0];
        wr_data_d = BSC_CLR_VAL;
        wr_en_d = 1'b0;
        zero_set_d = 1'b0;
        push_d = 1'b0;
        stack_top_entry_d = stack_top_entry_q;
        pc_load_d = 1'b0;
        pc_next_d = pc_next_q;
        flush_d = 1'b0;
        busy_d = 1'b0;
        case (state_q)
            BSC_ST_EXEC: begin
                if (exec_ok && is_skip && rd_data[instr[BSC_BIT_HI:BSC_BIT_LO]]) begin
                    flush_d = 1'b1;
                    busy_d = 1'b1;
                    state_d = BSC_ST_FLUSH;
                end else if (exec_ok && is_clr) begin
                    wr_en_d = 1'b1;
                    zero_set_d = 1'b1;
                end else if (exec_ok && is_call) begin
                    push_d = 1'b1;
                    stack_top_entry_d = pc_cur + BSC_PC_ONE;
                    pc_load_d = 1'b1;
                    pc_next_d = {program_counter_high_latch[BSC_LATCH_HI:BSC_LATCH_LO],
                        instr[BSC_LIT_HI:0]};
                    flush_d = 1'b1;
                    busy_d = 1'b1;
                    state_d = BSC_ST_FLUSH;
                end
            end
            BSC_ST_FLUSH: begin
                state_d = BSC_ST_EXEC;
            end
            default: begin
                state_d = BSC_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= BSC_ST_EXEC;
            reg_addr_q <= BSC_ADDR_RST;
            wr_data_q <= BSC_CLR_VAL;
            wr_en_q <= 1'b0;
            zero_set_q <= 1'b0;
            push_q <= 1'b0;
            stack_top_entry_q <= BSC_PC_RST;
            pc_load_q <= 1'b0;
            pc_next_q <= BSC_PC_RST;
            flush_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            reg_addr_q <= reg_addr_d;
            wr_data_q <= wr_data_d;
            wr_en_q <= wr_en_d;
            zero_set_q <= zero_set_d;
            push_q <= push_d;
            stack_top_entry_q <= stack_top_entry_d;
            pc_load_q <= pc_load_d;
            pc_next_q <= pc_next_d;
            flush_q <= flush_d;
            busy_q <= busy_d;
        end
    end

    // Counts the enabled cycles that a call has held the core.
    // A stall with the clock enable low does not advance the count.
    logic [1:0] occ_cnt_q;
    logic [1:0] occ_cnt_d;

    always_comb begin
        if (exec_ok && is_call) begin
            occ_cnt_d = 2'h1;
        end else if (state_q == BSC_ST_FLUSH && occ_cnt_q != 2'h0) begin
            occ_cnt_d = occ_cnt_q + 2'h1;
        end else begin
            occ_cnt_d = 2'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            occ_cnt_q <= 2'h0;
        end else if (clk_en) begin
            occ_cnt_q <= occ_cnt_d;
        end
    end

    // Checks beside the state machine; every one of them is cut short by reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_skip_flush: assert property (clk_en && exec_ok && is_skip
        && rd_data[instr[BSC_BIT_HI:BSC_BIT_LO]] |=> flush_q && busy_q
        && reg_addr_q == $past(instr[6:0]))
        else $error("skip with set bit did not flush");

    a_skip_noflush: assert property (clk_en && exec_ok && is_skip
        && !rd_data[instr[BSC_BIT_HI:BSC_BIT_LO]] |=> !flush_q && !wr_en_q
        && reg_addr_q == $past(instr[6:0]))
        else $error("skip with clear bit flushed");

    a_clear_write: assert property (clk_en && exec_ok && is_clr |=> wr_en_q
        && wr_data_q == 8'h00 && zero_set_q && reg_addr_q == $past(instr[6:0]))
        else $error("clear did not write zero");

    a_clear_single: assert property (clk_en && exec_ok && is_clr |=> !busy_q
        && !flush_q && state_q == BSC_ST_EXEC)
        else $error("clear took more than one cycle");

    a_call_push: assert property (clk_en && exec_ok && is_call |=> push_q
        && stack_top_entry_q == $past(pc_cur) + 13'h0001)
        else $error("call pushed wrong return address");

    a_stack_hold: assert property (clk_en && !(exec_ok && is_call) |=>
        $stable(stack_top_entry_q) && $stable(pc_next_q) && !push_q && !pc_load_q)
        else $error("return address or target moved without a call");

    a_call_low: assert property (clk_en && exec_ok && is_call |=> pc_load_q
        && pc_next_q[10:0] == $past(instr[10:0]))
        else $error("call loaded wrong low bits");

    a_call_high: assert property (clk_en && exec_ok && is_call |=>
        pc_next_q[12:11] == $past(program_counter_high_latch[4:3]))
        else $error("call loaded wrong high bits");

    a_call_two: assert property (clk_en && exec_ok && is_call ##1 clk_en |=>
        !busy_q && !push_q)
        else $error("call did not last two cycles");

    a_call_first: assert property (occ_cnt_q == 2'h1 |-> busy_q
        && state_q == BSC_ST_FLUSH)
        else $error("call released the core after one cycle");

    a_call_length: assert property (occ_cnt_q == 2'(BSC_CALL_CYCLES) |-> !busy_q
        && state_q == BSC_ST_EXEC)
        else $error("call held the core beyond two cycles");

    a_freeze_hold: assert property (!clk_en |=> $stable(state_q) && $stable(busy_q)
        && $stable(push_q) && $stable(flush_q) && $stable(wr_en_q)
        && $stable(stack_top_entry_q) && $stable(pc_next_q))
        else $error("state moved while the clock enable was low");

    a_zero_only: assert property (zero_set_q |-> wr_en_q && !push_q && !flush_q)
        else $error("zero flag changed by other instruction");

    a_skip_noflag: assert property (clk_en && exec_ok && is_skip |=> !zero_set_q
        && !push_q && !pc_load_q)
        else $error("skip touched the zero flag");

    a_call_noflag: assert property (clk_en && exec_ok && is_call |=> !zero_set_q
        && !wr_en_q)
        else $error("call touched the zero flag");

    a_flush_slot: assert property (clk_en && state_q == BSC_ST_FLUSH |=> !wr_en_q
        && !push_q && !flush_q && !zero_set_q)
        else $error("word in the discarded slot was executed");

    a_busy_flush: assert property (busy_q == flush_q)
        else $error("busy and flush pulses disagree");

    // Covers for taken and missed skips, clear, call and a stall while busy.
    c_skip: cover property (flush_q && !push_q);
    c_skip_miss: cover property (clk_en && exec_ok && is_skip
        && !rd_data[instr[BSC_BIT_HI:BSC_BIT_LO]]);
    c_clear: cover property (wr_en_q);
    c_call: cover property (push_q);
    c_stall: cover property (!clk_en && busy_q);
endmodule : bsc_exec

//--- testbench/bit_skip_clear_call_exec_tb.sv
// Self-checking bench for the skip, clear and call executor.
// Assumes the bench alone drives every port, with read data static per word.
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module bit_skip_clear_call_exec_tb
    import bsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [12:0] pc_cur = 13'h0000;
    logic [7:0] rd_data = 8'h00;
    logic [7:0] pch_latch = 8'h00;
    logic [6:0] reg_addr_q;
    logic [7:0] wr_data_q;
    logic wr_en_q, zero_set_q, push_q, pc_load_q, flush_q, busy_q;
    logic [12:0] stack_top_entry_q, pc_next_q;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    bsc_exec dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr(instr), .pc_cur(pc_cur), .rd_data(rd_data),
        .program_counter_high_latch(pch_latch), .reg_addr_q(reg_addr_q),
        .wr_data_q(wr_data_q), .wr_en_q(wr_en_q), .zero_set_q(zero_set_q),
        .push_q(push_q), .stack_top_entry_q(stack_top_entry_q), .pc_load_q(pc_load_q),
        .pc_next_q(pc_next_q), .flush_q(flush_q), .busy_q(busy_q));
    always #25 clk_sys = ~clk_sys;
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            give_verdict();
        end
    end
    // Offers two words back to back and stops where the first one's results stand.
    task automatic pair(input logic [13:0] a, input logic [13:0] b, input logic [7:0] rd);
        @(posedge clk_sys);
        instr <= a;
        rd_data <= rd;
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        instr <= b;
        @(negedge clk_sys);
    endtask : pair
    task automatic tail();
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        @(negedge clk_sys);
    endtask : tail
    task automatic t_skip(input logic [2:0] b, input logic hit);
        pair({BSC_OP_SKIP, b, 7'h15}, {BSC_OP_CLR, 7'h2a}, hit ? 8'h01 << b : ~(8'h01 << b));
        `CHK(flush_q, hit)
        `CHK(busy_q, hit)
        `CHK(reg_addr_q, 7'h15)
        `CHK(zero_set_q, 1'b0)
        tail();
        `CHK(wr_en_q, !hit)
        `CHK(zero_set_q, !hit)
    endtask : t_skip
    task automatic t_clear();
        pair({BSC_OP_CLR, 7'h7f}, 14'h0000, 8'hff);
        `CHK({wr_en_q, zero_set_q, flush_q}, 3'h6)
        `CHK(wr_data_q, 8'h00)
        `CHK(reg_addr_q, 7'h7f)
        tail();
        `CHK({wr_en_q, zero_set_q}, 2'h0)
    endtask : t_clear
    task automatic t_call(input logic [12:0] pc, input logic [7:0] lat, input logic [10:0] k);
        @(posedge clk_sys);
        pc_cur <= pc;
        pch_latch <= lat;
        pair({BSC_OP_CALL, k}, {BSC_OP_CLR, 7'h01}, 8'h00);
        `CHK(push_q, 1'b1)
        `CHK(stack_top_entry_q, pc + 13'h0001)
        `CHK(pc_load_q, 1'b1)
        `CHK(pc_next_q, {lat[4:3], k})
        `CHK(flush_q, 1'b1)
        `CHK(zero_set_q, 1'b0)
        tail();
        `CHK({wr_en_q, push_q, pc_load_q}, 3'h0)
        `CHK(stack_top_entry_q, pc + 13'h0001)
    endtask : t_call
    // Holds a call in its second cycle with the clock enable low, then resets mid-run.
    task automatic t_stall();
        @(posedge clk_sys);
        pc_cur <= 13'h0123;
        pch_latch <= 8'h08;
        instr <= {BSC_OP_CALL, 11'h456};
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        instr <= {BSC_OP_CLR, 7'h33};
        clk_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK({push_q, flush_q, busy_q}, 3'h7)
        `CHK({stack_top_entry_q, pc_next_q}, {13'h0124, 13'h0c56})
        @(posedge clk_sys);
        clk_en <= 1'b1;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        @(negedge clk_sys);
        `CHK({wr_en_q, push_q, flush_q, zero_set_q}, 4'h0)
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        `CHK({stack_top_entry_q, pc_next_q}, {BSC_PC_RST, BSC_PC_RST})
        t_clear();
    endtask : t_stall
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        `CHK({push_q, wr_en_q, flush_q, pc_load_q, zero_set_q}, 5'h00)
        for (int i = 0; i < 8; i++) begin
            t_skip(3'(i), 1'b1);
            t_skip(3'(i), 1'b0);
        end
        t_clear();
        t_call(13'h0ffe, 8'h18, 11'h7ff);
        t_call(13'h1fff, 8'he7, 11'h001);
        t_stall();
        give_verdict();
    end
endmodule : bit_skip_clear_call_exec_tb
